// ---- rtl/gpib_status.v ----
// GPIB condition status word and non-controller device-mode logic
//
// Decided for this implementation: the address map and the address-and-strobe port.
`include "gpib_status_defines.vh"

// How it works
// - Sixteen-bit status word, fourteen bits meaningful
// - Fixed bit positions for each status flag
// - Error set on failed op, cleared otherwise
// - Timeout set on wait or transfer overrun
// - Timeout cleared at start, wait command or clean transfer end
// - End set on END/EOS read, cleared at start
// - Shadow handshake may report end anytime
// - SRQ seen only as controller, cleared otherwise
// - Later revision mode: SRQ flag follows line
// - Wants service from hex 40, cleared on read
// - Done flag set while no transfer runs
// - Request service and load poll status byte
// - Local return clears remote unless lockout
// - Software sets or clears individual status bit
// - Local parallel poll configure or unconfigure
// - Wait detects trigger, clear, remote, lockout
// - Setting enables EOI with final written byte
// - Incoming bytes compared with EOS character
// - Outgoing bytes compared with EOS for EOI
// - Select DMA or programmed I/O transfers
// - Primary address, optional secondary address
// - Take or release system controller role
module gpib_status (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Register port
    input  wire [7:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    // Bus line levels and decoded bus events
    input  wire        srq_line,
    input  wire        atn_line,
    input  wire        ren_line,
    input  wire        cic_in,
    input  wire        talk_in,
    input  wire        listen_in,
    input  wire        shadow_hs,
    input  wire        ev_trigger,
    input  wire        ev_dev_clear,
    input  wire        ev_lockout,
    input  wire        ev_my_listen,
    input  wire        ev_go_local,
    // Transfer engine
    input  wire        xfer_busy,
    input  wire        xfer_done,
    input  wire        xfer_error,
    input  wire        xfer_timeout,
    input  wire        xfer_end_seen,
    input  wire        xfer_is_read,
    input  wire        xfer_last,
    input  wire [7:0]  rx_byte,
    input  wire        rx_valid,
    input  wire [7:0]  tx_byte,
    input  wire        tx_valid,
    // Serial poll by the controller
    input  wire        poll_taken,
    // Outputs to the bus side
    output reg         srq_req,
    output reg  [7:0]  poll_byte,
    output reg         ist_bit,
    output reg         pp_local_cfg,
    output reg         eoi_out,
    output wire        rx_stop,
    output reg         use_dma,
    output reg  [4:0]  pad,
    output reg  [4:0]  sad,
    output reg         sad_en,
    output reg         sys_ctrl,
    output reg         xfer_start,
    output wire        wait_active,
    output reg         wait_hit
);

    reg        err_q;
    reg        timeout_flag_q;
    reg        end_q;
    reg        want_q;
    reg        lock_q;
    reg        rem_q;
    reg        trig_q;
    reg        dclr_q;
    reg        busy_q;
    reg  [7:0] cfg_q;
    reg  [7:0] eos_q;
    reg [15:0] tlimit_q;
    reg [15:0] wmask_q;
    reg        wait_q;
    reg [15:0] wcnt_q;
    reg [7:0]  dev_stb_q;
    wire [15:0] status_w;
    wire        srq_seen;
    wire        ctl_wr;
    wire        start_cmd;
    wire        wait_cmd;
    wire        wait_to;

    // Register write decode
    function is_wr;
        input [7:0] a;
        input [7:0] ofs;
        begin
            is_wr = wr && (a == ofs);
        end
    endfunction

    assign ctl_wr    = is_wr(addr, `OFS_CONTROL);
    assign start_cmd = ctl_wr && wdata[`CT_START];
    assign wait_cmd  = ctl_wr && wdata[`CT_WAIT];

    // SRQ flag: strict controller gating unless later-revision mode picked
    assign srq_seen = cfg_q[`CF_SRQ_LV] ? srq_line
                    : (srq_line && cic_in && !(talk_in && !atn_line));

    // Status word assembly; bits 10:9 are unused and read zero
    assign status_w = {err_q, timeout_flag_q, end_q, srq_seen, want_q, 2'b00,
                       !busy_q, lock_q, rem_q, cic_in, atn_line,
                       talk_in, listen_in, trig_q, dclr_q};

    // Wait times out only when timeout is one of the chosen events
    assign wait_active = wait_q;
    assign wait_to     = wait_q && wmask_q[`ST_TIMEOUT_FLAG] && (wcnt_q >= tlimit_q);

    // EOS matching on receive may end the read
    assign rx_stop = rx_valid && cfg_q[`CF_EOS_RD] && (rx_byte == eos_q);

    // Transfer bookkeeping: error, timeout, end, done
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            err_q      <= 1'b0;
            timeout_flag_q     <= 1'b0;
            end_q      <= 1'b0;
            busy_q     <= 1'b0;
            xfer_start <= 1'b0;
        end else begin
            xfer_start <= start_cmd;
            if (start_cmd) begin
                busy_q <= 1'b1;
                end_q  <= 1'b0;
                timeout_flag_q <= 1'b0;
            end else if (xfer_done) begin
                busy_q <= 1'b0;
            end else if (xfer_busy) begin
                busy_q <= 1'b1;
            end
            if (xfer_done) begin
                err_q  <= xfer_error || xfer_timeout;
                timeout_flag_q <= xfer_timeout;
            end else if (wait_to) begin
                timeout_flag_q <= 1'b1;
            end else if (wait_cmd) begin
                timeout_flag_q <= 1'b0;
            end
            // Set wins over the start clear, so a late END is never lost
            if ((xfer_done && xfer_is_read && xfer_end_seen) ||
                (shadow_hs && xfer_end_seen)) begin
                end_q <= 1'b1;
            end
        end
    end

    // Device-mode events: trigger, clear, remote, lockout
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trig_q <= 1'b0;
            dclr_q <= 1'b0;
            rem_q  <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            // Software clear first, so a same-cycle event still lands
            if (ctl_wr && wdata[`CT_CLR_EV]) begin
                trig_q <= 1'b0;
                dclr_q <= 1'b0;
            end
            if (ev_trigger)
                trig_q <= 1'b1;
            if (ev_dev_clear)
                dclr_q <= 1'b1;
            if (!ren_line) begin
                rem_q  <= 1'b0;
                lock_q <= 1'b0;
            end else begin
                if (ev_lockout)
                    lock_q <= 1'b1;
                if (ev_my_listen)
                    rem_q <= 1'b1;
                else if (ev_go_local)
                    rem_q <= 1'b0;
                else if (ctl_wr && wdata[`CT_LOCAL] && !lock_q)
                    rem_q <= 1'b0;
            end
        end
    end

    // Service request and serial poll byte
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            srq_req   <= 1'b0;
            poll_byte <= 8'h00;
        end else begin
            if (is_wr(addr, `OFS_POLL_BYTE))
                poll_byte <= wdata[7:0];
            if (ctl_wr && wdata[`CT_RSV] && !cic_in)
                srq_req <= 1'b1;
            else if (poll_taken)
                srq_req <= 1'b0;
        end
    end

    // Polled device status byte; read-clear loses to a new set
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dev_stb_q <= 8'h00;
            want_q    <= 1'b0;
        end else begin
            if (is_wr(addr, `OFS_DEV_STB)) begin
                dev_stb_q <= wdata[7:0];
                want_q    <= |(wdata[7:0] & `STB_RQS_MASK);
            end else if (ctl_wr && wdata[`CT_STB_RD]) begin
                want_q    <= 1'b0;
            end
        end
    end

    // Parallel poll, system control, configuration, addressing
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ist_bit      <= 1'b0;
            sys_ctrl     <= 1'b0;
            cfg_q        <= `RST_CONFIG;
            eos_q        <= 8'h00;
            pad          <= `RST_PAD;
            sad          <= `RST_SAD;
            sad_en       <= 1'b0;
            tlimit_q     <= `RST_TLIMIT;
        end else begin
            if (ctl_wr && wdata[`CT_IST_S])
                ist_bit <= 1'b1;
            else if (ctl_wr && wdata[`CT_IST_C])
                ist_bit <= 1'b0;
            if (ctl_wr && wdata[`CT_SC_REQ])
                sys_ctrl <= 1'b1;
            else if (ctl_wr && wdata[`CT_SC_REL])
                sys_ctrl <= 1'b0;
            if (is_wr(addr, `OFS_CONFIG))
                cfg_q <= wdata[7:0];
            if (is_wr(addr, `OFS_EOS_CHAR))
                eos_q <= wdata[7:0];
            if (is_wr(addr, `OFS_ADDRESS)) begin
                pad    <= wdata[4:0];
                sad    <= wdata[12:8];
                sad_en <= wdata[15];
            end
            if (is_wr(addr, `OFS_TIME_LIMIT))
                tlimit_q <= wdata;
        end
    end

    // Config fields fan out as plain levels
    always @* begin
        use_dma      = cfg_q[`CF_DMA];
        pp_local_cfg = cfg_q[`CF_PPCFG];
    end

    // EOI on last byte or on an outgoing EOS match
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            eoi_out <= 1'b0;
        else
            eoi_out <= tx_valid && ((cfg_q[`CF_EOT] && xfer_last) ||
                       (cfg_q[`CF_EOS_WR] && (tx_byte == eos_q)));
    end

    // Event wait: mask over status word, with its own cycle counter
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_q   <= 1'b0;
            wmask_q  <= 16'h0000;
            wcnt_q   <= 16'h0000;
            wait_hit <= 1'b0;
        end else begin
            wait_hit <= 1'b0;
            if (wait_cmd) begin
                wait_q  <= 1'b1;
                wcnt_q  <= 16'h0000;
            end else if (wait_q) begin
                wcnt_q <= wcnt_q + 16'h0001;
                if (((status_w & wmask_q) != 16'h0000) || wait_to) begin
                    wait_q   <= 1'b0;
                    wait_hit <= 1'b1;
                end
            end
            // Mask comes from a write to hex 1c, the same offset as the device status byte
            if (is_wr(addr, `OFS_TIME_LIMIT + 8'h04))
                wmask_q <= wdata;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `OFS_STATUS:     rdata <= status_w;
                `OFS_CONFIG:     rdata <= {8'h00, cfg_q};
                `OFS_ADDRESS:    rdata <= {sad_en, 2'b00, sad, 3'b000, pad};
                `OFS_POLL_BYTE:  rdata <= {7'h00, srq_req, poll_byte};
                `OFS_EOS_CHAR:   rdata <= {8'h00, eos_q};
                `OFS_TIME_LIMIT: rdata <= tlimit_q;
                `OFS_DEV_STB:    rdata <= {8'h00, dev_stb_q};
                default:         rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

endmodule // gpib_status

// ---- shared/gpib_status_defines.vh ----
// Register offsets, field positions and reset values for the GPIB status block
`ifndef GPIB_STATUS_DEFINES_VH
`define GPIB_STATUS_DEFINES_VH

// Register byte offsets
`define OFS_STATUS      8'h00
`define OFS_CONTROL     8'h04
`define OFS_CONFIG      8'h08
`define OFS_ADDRESS     8'h0c
`define OFS_POLL_BYTE   8'h10
`define OFS_EOS_CHAR    8'h14
`define OFS_TIME_LIMIT  8'h18
`define OFS_DEV_STB     8'h1c

// Status word bit positions
`define ST_ERR    15
`define ST_TIMEOUT_FLAG   14
`define ST_END    13
`define ST_SRQ    12
`define ST_WANT   11
`define ST_DONE   8
`define ST_LOCK   7
`define ST_REM    6
`define ST_CIC    5
`define ST_ATN    4
`define ST_TALK   3
`define ST_LISN   2
`define ST_TRIG   1
`define ST_DCLR   0

// Control register command bits (write one to act)
`define CT_RSV    0
`define CT_LOCAL  1
`define CT_IST_S  2
`define CT_IST_C  3
`define CT_SC_REQ 4
`define CT_SC_REL 5
`define CT_START  6
`define CT_WAIT   7
`define CT_STB_RD 8
`define CT_CLR_EV 9

// Config register fields
`define CF_EOT    0
`define CF_EOS_RD 1
`define CF_EOS_WR 2
`define CF_DMA    3
`define CF_PPCFG  4
`define CF_SRQ_LV 5
`define CF_WAIT_T 6

// Serial poll bit that means a device wants service
`define STB_RQS_MASK 8'h40

// Reset values
`define RST_CONFIG   8'h01
`define RST_PAD      5'h00
`define RST_SAD      5'h00
`define RST_TLIMIT   16'hffff
`endif

// ---- verif/gpib_bus_model.sv ----
// Behavioural controller in charge and instruments on the far side
module gpib_bus_model (
    // Clock
    input  wire logic clk,
    // Line levels and roles
    output logic      srq_line,
    output logic      atn_line,
    output logic      ren_line,
    output logic      cic_in,
    output logic      talk_in,
    output logic      listen_in,
    output logic      shadow_hs,
    // One-cycle bus events
    output logic      ev_trigger,
    output logic      ev_dev_clear,
    output logic      ev_lockout,
    output logic      ev_my_listen,
    output logic      ev_go_local,
    output logic      poll_taken
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet bus until the bench asks for something
    initial begin
        {srq_line, atn_line, ren_line, cic_in, talk_in, listen_in, shadow_hs} = 7'h00;
        {ev_trigger, ev_dev_clear, ev_lockout, ev_my_listen, ev_go_local, poll_taken} = 6'h00;
    end

    // Levels move just after an edge and hold
    task automatic lines(input logic [5:0] v);
        @(posedge clk);
        {srq_line, atn_line, ren_line, cic_in, talk_in, listen_in} <= v;
    endtask

    // Events: trigger, clear, lockout, listen, local, poll; delay models a slow controller
    task automatic pulse(input int k, input int slow);
        repeat (slow) @(posedge clk);
        @(posedge clk);
        {ev_trigger, ev_dev_clear, ev_lockout, ev_my_listen, ev_go_local, poll_taken} <= 6'h20 >> k;
        @(posedge clk);
        {ev_trigger, ev_dev_clear, ev_lockout, ev_my_listen, ev_go_local, poll_taken} <= 6'h00;
    endtask
endmodule // gpib_bus_model

// ---- verif/gpib_status_assertions.sv ----
// Port-level checks for the status block
module gpib_status_assertions (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        cic_in,
    input wire logic        xfer_last,
    input wire logic [7:0]  rx_byte,
    input wire logic        rx_valid,
    input wire logic [7:0]  tx_byte,
    input wire logic        tx_valid,
    input wire logic        srq_req,
    input wire logic [7:0]  poll_byte,
    input wire logic        ist_bit,
    input wire logic        pp_local_cfg,
    input wire logic        eoi_out,
    input wire logic        rx_stop,
    input wire logic        use_dma,
    input wire logic [4:0]  pad,
    input wire logic        sad_en,
    input wire logic        sys_ctrl,
    input wire logic        xfer_start
);
    logic [7:0] cfg_q;
    logic [7:0] eos_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Shadow of config and end-string char, so checks need no hierarchy
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= 8'h01;
            eos_q <= 8'h00;
        end else if (wr) begin
            cfg_q <= (addr == 8'h08) ? wdata[7:0] : cfg_q;
            eos_q <= (addr == 8'h14) ? wdata[7:0] : eos_q;
        end
    end

    sequence s_ctl(int b);
        wr && addr == 8'h04 && wdata[b];
    endsequence

    a_rdata_idle: assert property (!rd |=> rdata == 16'h0000) else $error("rdata not idle");
    a_start_pulse: assert property (s_ctl(6) |=> xfer_start) else $error("no start pulse");
    a_rsv_req: assert property (s_ctl(0) and !cic_in |=> srq_req) else $error("no service request");
    a_poll_load: assert property (wr && addr == 8'h10 |=> poll_byte == $past(wdata[7:0]))
        else $error("poll byte not loaded");
    a_ist_set: assert property (s_ctl(2) |=> ist_bit) else $error("ist not set");
    a_ist_clear: assert property (s_ctl(3) and !wdata[2] |=> !ist_bit) else $error("ist not cleared");
    a_pp_local: assert property (pp_local_cfg == cfg_q[4]) else $error("pp config wrong");
    a_eot_last: assert property (tx_valid && xfer_last && cfg_q[0] |=> eoi_out) else $error("no eoi last");
    a_eos_read: assert property (rx_valid && cfg_q[1] && rx_byte == eos_q |-> rx_stop) else $error("no stop");
    a_eos_write: assert property (tx_valid && cfg_q[2] && tx_byte == eos_q |=> eoi_out) else $error("no eoi");
    a_dma_select: assert property (use_dma == cfg_q[3]) else $error("dma select wrong");
    a_addr_load: assert property (wr && addr == 8'h0c |=> pad == $past(wdata[4:0]) && sad_en == $past(wdata[15]))
        else $error("address not loaded");
    a_sys_take: assert property (s_ctl(4) |=> sys_ctrl) else $error("system control not taken");
endmodule // gpib_status_assertions

bind gpib_status gpib_status_assertions u_chk (.*);

// ---- verif/gpib_status_tb.sv ----
// Self-checking bench for the status block
module gpib_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rstn, wr, rd, xfer_busy, xfer_done, xfer_error, xfer_timeout, xfer_end_seen;
    logic        xfer_is_read, xfer_last, rx_valid, tx_valid;
    logic [7:0]  addr, rx_byte, tx_byte, poll_byte;
    logic [15:0] wdata, rdata, v;
    logic        srq_line, atn_line, ren_line, cic_in, talk_in, listen_in, shadow_hs;
    logic        ev_trigger, ev_dev_clear, ev_lockout, ev_my_listen, ev_go_local, poll_taken;
    logic        srq_req, ist_bit, pp_local_cfg, eoi_out, rx_stop, use_dma, sad_en, sys_ctrl;
    logic        xfer_start, wait_active, wait_hit;
    logic [4:0]  pad, sad;
    int          miscompares, checks_done, i;

    gpib_status uut (.*);
    gpib_bus_model bus (.*);

    // 25 MHz
    always #20 clk = ~clk;

    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One-cycle strobes; the gap edge keeps a strobe from being set and cleared at once
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdata;
    endtask

    task automatic st(input logic [15:0] e);
        rreg(8'h00, v);
        chk("status", v, e);
    endtask

    // Transfer end with its qualifiers; busy drops with it
    task automatic finish_io(input logic [3:0] q);
        @(posedge clk);
        {xfer_error, xfer_timeout, xfer_end_seen, xfer_is_read} <= q;
        xfer_done <= 1'h1;
        xfer_busy <= 1'h0;
        @(posedge clk);
        xfer_done <= 1'h0;
    endtask

    task automatic t_reset;
        rreg(8'h08, v);
        chk("config", v, 16'h0001);
        rreg(8'h18, v);
        chk("time_limit", v, 16'hffff);
        rreg(8'h40, v);
        chk("unmapped", v, 16'h0000);
        st(16'h0100);
    endtask

    task automatic t_roles;
        bus.lines(6'h3f);
        st(16'h113c);
        bus.lines(6'h3b);
        st(16'h011c);
        wreg(8'h08, 16'h0021);
        st(16'h111c);
        wreg(8'h08, 16'h0001);
        bus.lines(6'h00);
        st(16'h0100);
    endtask

    task automatic t_xfer;
        wreg(8'h04, 16'h0040);
        #1 chk("xfer_start", xfer_start, 16'h0001);
        xfer_busy <= 1'h1;
        st(16'h0000);
        finish_io(4'hf);
        st(16'he100);
        wreg(8'h04, 16'h0040);
        xfer_busy <= 1'h1;
        st(16'h8000);
        finish_io(4'h0);
        st(16'h0100);
    endtask

    task automatic t_service;
        wreg(8'h1c, 16'h0040);
        st(16'h0900);
        wreg(8'h04, 16'h0100);
        st(16'h0100);
        wreg(8'h10, 16'h0041);
        wreg(8'h04, 16'h0001);
        rreg(8'h10, v);
        chk("poll_reg", v, 16'h0141);
        chk("poll_byte", poll_byte, 16'h0041);
        bus.pulse(5, 3);
        #1 chk("srq_req", srq_req, 16'h0000);
    endtask

    task automatic t_local;
        bus.lines(6'h08);
        bus.pulse(3, 0);
        st(16'h0140);
        wreg(8'h04, 16'h0002);
        st(16'h0100);
        bus.pulse(3, 0);
        bus.pulse(2, 0);
        wreg(8'h04, 16'h0002);
        st(16'h01c0);
        bus.lines(6'h00);
        st(16'h0100);
    endtask

    task automatic t_setup;
        wreg(8'h04, 16'h0004);
        #1 chk("ist", ist_bit, 16'h0001);
        wreg(8'h04, 16'h0008);
        #1 chk("ist", ist_bit, 16'h0000);
        wreg(8'h08, 16'h0019);
        #1 chk("pp_dma", {pp_local_cfg, use_dma}, 16'h0003);
        wreg(8'h04, 16'h0010);
        #1 chk("sys_ctrl", sys_ctrl, 16'h0001);
        wreg(8'h04, 16'h0020);
        #1 chk("sys_ctrl", sys_ctrl, 16'h0000);
        wreg(8'h0c, 16'h8503);
        #1 chk("address", {sad_en, sad, pad}, 16'h04a3);
    endtask

    task automatic t_eos;
        wreg(8'h14, 16'h000a);
        wreg(8'h08, 16'h0007);
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            rx_byte <= 8'h0a + i[7:0];
            tx_byte <= 8'h0a + i[7:0];
            rx_valid <= 1'h1;
            tx_valid <= 1'h1;
            xfer_last <= (i == 2);
            #1 chk("rx_stop", rx_stop, {15'h0, i == 0});
            @(posedge clk);
            {rx_valid, tx_valid, xfer_last} <= 3'h0;
            #1 chk("eoi_out", eoi_out, {15'h0, i == 0 || i == 2});
        end
        wreg(8'h08, 16'h0001);
    endtask

    task automatic t_wait(input logic [15:0] mask, input logic [15:0] e);
        wreg(8'h18, 16'h0005);
        wreg(8'h1c, mask);
        wreg(8'h04, 16'h0080);
        #1 chk("wait_active", wait_active, 16'h0001);
        fork
            if (mask[1]) bus.pulse(0, 2);
            for (i = 0; i < 40 && wait_hit !== 1'h1; i++) @(posedge clk) #1;
        join
        if (wait_hit !== 1'h1) begin
            miscompares++;
            $display("CHECK FAILED wait_hit expected 1 seen 0");
            end_of_test();
        end
        st(e);
        wreg(8'h04, 16'h0200);
    endtask

    initial begin
        clk = 1'h0;
        rstn = 1'h0;
        {wr, rd, xfer_busy, xfer_done, xfer_error, xfer_timeout, xfer_end_seen} = 7'h00;
        {xfer_is_read, xfer_last, rx_valid, tx_valid} = 4'h0;
        {addr, rx_byte, tx_byte, wdata} = 40'h0;
        miscompares = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        t_reset();
        t_roles();
        t_xfer();
        t_service();
        t_local();
        t_setup();
        t_eos();
        t_wait(16'h0002, 16'h0102);
        t_wait(16'h4000, 16'h4100);
        end_of_test();
    end
endmodule // gpib_status_tb
